// *** hdl/core_status_mode_bits.v ***
// Contract
// - Arith16 bit selects right-aligned 16-bit operations.
// - Arith16 shapes shift, limit, round, moves.
// - Reset clears arith16, endless, loop, dpmult.
// - Endless flag sets on endless loop start.
// - Endless flag stacked on entry, restored exit.
// - Interrupt return restores both loop flags.
// - Loop flag gates loop-end detection.
// - Loop flag stacked on entry, restored exit.
// - Dpmult bit enables 48x48 to 96 mode.
// - Dpmult alters only designated operations.
// - Compat zeroes top byte of control moves.
// - Compat zeroes top byte from status sources.
// - Compat keeps top byte of status destinations.
// - Normal count: zero skips, max full range.
// - Compat count: zero 65536, max 65535.
// - Compat ignores upper address byte for mapping.
// - Compat zeroes upper byte of address reads.
// - Compat change acts three cycles later.
//
// Local design decisions: the plain strobed port and the register addresses.
`include "core_status_mode_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module core_status_mode_bits (
  input  wire        clk_sys_i,        // Core clock, 25 MHz.
  input  wire        rst_b_i,          // Asynchronous reset, active low.
  input  wire [3:0]  addr_i,           // Register address.
  input  wire [23:0] wdata_i,          // Register write data.
  input  wire        wr_i,             // Register write strobe.
  input  wire        rd_i,             // Register read strobe.
  output reg  [23:0] rdata_o,          // Read data, one cycle later.
  input  wire        loop_start_i,     // Counted loop begins.
  input  wire        endless_start_i,  // Endless loop begins.
  input  wire        loop_exit_i,      // Loop terminates.
  input  wire        rti_i,            // Return from long interrupt.
  input  wire        loop_end_hit_i,   // Fetch reached loop end address.
  input  wire [23:0] loop_count_i,     // Loop count being loaded.
  input  wire        mv_ctrl_i,        // Move touches a control register.
  input  wire        mv_src_stat_i,    // Move source is status or mode register.
  input  wire        mv_dst_stat_i,    // Move destination is status or mode register.
  input  wire [23:0] mv_data_i,        // Move data in.
  input  wire [23:0] mv_dst_old_i,     // Old destination contents.
  input  wire        agu_rd_i,         // Address unit register read.
  input  wire [23:0] agu_data_i,       // Address unit value.
  input  wire [23:0] addr_in_i,        // Memory address to map.
  input  wire        dp_op_i,          // Designated dpmult operation.
  output reg         sixteen_bit_arith_mode_o, // Arith16 mode.
  output reg         double_prec_mult_mode_o,  // Dpmult mode.
  output reg         dp_op_alter_o,    // Designated operation altered.
  output reg         compat16_mode_o,  // Effective compat mode.
  output reg         loop_end_check_o, // Loop end detected.
  output reg  [24:0] loop_passes_o,    // Body pass count.
  output reg  [23:0] mv_result_o,      // Move result after masking.
  output reg  [23:0] agu_result_o,     // Address read after masking.
  output reg  [23:0] map_addr_o        // Address used for memory mapping.
);

  // ==========================================================
  // Status register bits and stack.
  // ==========================================================
  reg         arith16_r;
  reg         endless_r;
  reg         loop_r;
  reg         dpmult_r;
  reg         compat_r;
  reg  [1:0]  compat_dly_r;
  reg         compat_eff_r;
  reg         compat_pend_r;
  wire [1:0]  stack_top;
  wire [3:0]  stack_depth;
  wire [24:0] passes_nxt;
  wire        wr_status = wr_i && (addr_i == `CSM_OFF_STATUS);
  wire        push = loop_start_i || endless_start_i;
  wire        pop  = loop_exit_i || rti_i;

  // Saves the loop flags on every loop entry.
  flag_stack u_stack (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .push_i      (push),
    .pop_i       (pop),
    .push_data_i ({endless_r, loop_r}),
    .top_o       (stack_top),
    .depth_o     (stack_depth)
  );

  // Maps the loaded count to passes under the effective mode.
  loop_count_map u_map (
    .compat_i (compat_eff_r),
    .count_i  (loop_count_i),
    .passes_o (passes_nxt)
  );

  // Mode bits follow software writes only.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      arith16_r <= 1'b0;
      dpmult_r  <= 1'b0;
      compat_r  <= 1'b0;
    end else if (wr_status) begin
      arith16_r <= wdata_i[`CSM_BIT_ARITH16];
      dpmult_r  <= wdata_i[`CSM_BIT_DPMULT];
      compat_r  <= wdata_i[`CSM_BIT_COMPAT];
    end
  end

  // Loop flags: hardware events win over a software write in the same cycle.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      endless_r <= 1'b0;
      loop_r    <= 1'b0;
    end else if (endless_start_i) begin
      endless_r <= 1'b1;
      loop_r    <= 1'b1;
    end else if (loop_start_i) begin
      loop_r    <= 1'b1;
    end else if (pop) begin
      endless_r <= stack_top[1];
      loop_r    <= stack_top[0];
    end else if (wr_status) begin
      endless_r <= wdata_i[`CSM_BIT_ENDLESS];
      loop_r    <= wdata_i[`CSM_BIT_LOOP];
    end
  end

  // ==========================================================
  // Delayed compatibility mode.
  // ==========================================================
  // A change of the compat bit reaches the datapath three cycles later.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compat_dly_r  <= 2'h0;
      compat_pend_r <= 1'b0;
      compat_eff_r  <= 1'b0;
    end else if (compat_pend_r) begin
      if (compat_dly_r == 2'h1) begin
        compat_eff_r  <= compat_r;
        compat_pend_r <= 1'b0;
      end
      compat_dly_r <= compat_dly_r - 2'h1;
    end else if (compat_r != compat_eff_r) begin
      compat_pend_r <= 1'b1;
      compat_dly_r  <= `CSM_COMPAT_DELAY - 2'h1;
    end
  end

  // ==========================================================
  // Datapath-facing outputs.
  // ==========================================================
  // All outputs register their combinational results.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sixteen_bit_arith_mode_o <= 1'b0;
      double_prec_mult_mode_o  <= 1'b0;
      dp_op_alter_o            <= 1'b0;
      compat16_mode_o          <= 1'b0;
      loop_end_check_o         <= 1'b0;
      loop_passes_o            <= 25'h0000000;
      mv_result_o              <= 24'h000000;
      agu_result_o             <= 24'h000000;
      map_addr_o               <= 24'h000000;
    end else begin
      sixteen_bit_arith_mode_o <= arith16_r;
      double_prec_mult_mode_o  <= dpmult_r;
      dp_op_alter_o            <= dpmult_r && dp_op_i;
      compat16_mode_o          <= compat_eff_r;
      loop_end_check_o         <= loop_r && loop_end_hit_i;
      loop_passes_o            <= passes_nxt;
      if (compat_eff_r && mv_dst_stat_i) begin
        mv_result_o <= (mv_dst_old_i & `CSM_UPPER_MASK) |
                       (mv_data_i & ~`CSM_UPPER_MASK);
      end else if (compat_eff_r && (mv_ctrl_i || mv_src_stat_i)) begin
        mv_result_o <= mv_data_i & ~`CSM_UPPER_MASK;
      end else begin
        mv_result_o <= mv_data_i;
      end
      agu_result_o <= (compat_eff_r && agu_rd_i) ?
                      (agu_data_i & ~`CSM_UPPER_MASK) : agu_data_i;
      map_addr_o   <= compat_eff_r ?
                      (addr_in_i & ~`CSM_UPPER_MASK) : addr_in_i;
    end
  end

  // ==========================================================
  // Register read port.
  // ==========================================================
  // Read data stand only in the cycle after the strobe.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 24'h000000;
    end else if (!rd_i) begin
      rdata_o <= 24'h000000;
    end else if (addr_i == `CSM_OFF_STATUS) begin
      rdata_o <= {6'h00, arith16_r, endless_r, loop_r, dpmult_r, compat_r, 13'h0000};
    end else if (addr_i == `CSM_OFF_STACK_TOP) begin
      rdata_o <= {18'h00000, stack_depth, stack_top};
    end else if (addr_i == `CSM_OFF_LOOP_CNT) begin
      rdata_o <= passes_nxt[23:0];
    end else if (addr_i == `CSM_OFF_COMPAT_EFF) begin
      rdata_o <= {23'h000000, compat_eff_r};
    end else begin
      rdata_o <= 24'h000000;
    end
  end

endmodule // core_status_mode_bits
`default_nettype wire

// *** hdl/core_status_mode_defs.vh ***
`ifndef CORE_STATUS_MODE_DEFS_VH
`define CORE_STATUS_MODE_DEFS_VH

// ==========================================================
// Register map of the status and mode bank.
// ==========================================================
`define CSM_ADDR_W          4
`define CSM_OFF_STATUS      4'h0
`define CSM_OFF_STACK_TOP   4'h1
`define CSM_OFF_LOOP_CNT    4'h2
`define CSM_OFF_COMPAT_EFF  4'h3

// ==========================================================
// Field positions inside the 24-bit status register.
// ==========================================================
`define CSM_BIT_ARITH16     17
`define CSM_BIT_ENDLESS     16
`define CSM_BIT_LOOP        15
`define CSM_BIT_DPMULT      14
`define CSM_BIT_COMPAT      13
`define CSM_MODE_MASK       24'h03e000
`define CSM_UPPER_MASK      24'hff0000
`define CSM_RESET_VAL       24'h000000

// ==========================================================
// Timing and sizing.
// ==========================================================
`define CSM_COMPAT_DELAY    2'h3
`define CSM_STACK_DEPTH     16
`define CSM_STACK_PTR_W     4

`endif

// *** hdl/flag_stack.v ***
`timescale 1ns/1ps
`default_nettype none

// Small flip-flop stack holding the two loop flags per nesting level.
module flag_stack (
  input  wire       clk_sys_i,  // Core clock.
  input  wire       rst_b_i,    // Asynchronous reset, active low.
  input  wire       push_i,     // Push request.
  input  wire       pop_i,      // Pop request.
  input  wire [1:0] push_data_i,// Flags to save.
  output wire [1:0] top_o,      // Flags on top of stack.
  output wire [3:0] depth_o     // Number of held entries.
);

  reg  [1:0] entry_r [0:15];
  reg  [3:0] ptr_r;
  wire [3:0] top_idx = ptr_r - 4'h1;
  genvar     g;

  // Pointer moves up on push and down on pop; push wins if both.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr_r <= 4'h0;
    end else if (push_i) begin
      ptr_r <= ptr_r + 4'h1;
    end else if (pop_i && ptr_r != 4'h0) begin
      ptr_r <= ptr_r - 4'h1;
    end
  end

  // Each entry loads when the pointer names it on a push.
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_entry
      always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          entry_r[g] <= 2'h0;
        end else if (push_i && ptr_r == g) begin
          entry_r[g] <= push_data_i;
        end
      end
    end
  endgenerate

  assign top_o   = (ptr_r == 4'h0) ? 2'h0 : entry_r[top_idx];
  assign depth_o = ptr_r;

endmodule // flag_stack
`default_nettype wire

// *** hdl/loop_count_map.v ***
`timescale 1ns/1ps
`default_nettype none

// Turns a loaded loop count into the number of body passes.
module loop_count_map (
  input  wire        compat_i,  // Effective compatibility mode.
  input  wire [23:0] count_i,   // Count as loaded.
  output wire [24:0] passes_o   // Resulting number of passes.
);

  wire [15:0] low16 = count_i[15:0];

  // Normal mode runs the count as given, zero skips; compat uses 16 bits, zero means 65536.
  assign passes_o = !compat_i ? {1'b0, count_i} :
                    (low16 == 16'h0000) ? 25'h0010000 : {9'h000, low16};

endmodule // loop_count_map
`default_nettype wire

// *** testbench/csm_checker_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker for the status and mode bank.
// ==========================================
module csm_checker (
  input wire logic        clk_sys_i,                // Core clock.
  input wire logic        rst_b_i,                  // Reset, active low.
  input wire logic [3:0]  addr_i,                   // Address.
  input wire logic [23:0] wdata_i,                  // Write data.
  input wire logic        wr_i,                     // Write strobe.
  input wire logic        loop_end_hit_i,           // Loop end hit.
  input wire logic [23:0] loop_count_i,             // Loop count.
  input wire logic        mv_ctrl_i,                // Control move.
  input wire logic        mv_dst_stat_i,            // Status destination move.
  input wire logic [23:0] mv_data_i,                // Move data.
  input wire logic        agu_rd_i,                 // Address read.
  input wire logic [23:0] agu_data_i,               // Address data.
  input wire logic        dp_op_i,                  // Dpmult operation.
  input wire logic [23:0] rdata_o,                  // Read data.
  input wire logic        sixteen_bit_arith_mode_o, // Arith16 mode.
  input wire logic        double_prec_mult_mode_o,  // Dpmult mode.
  input wire logic        dp_op_alter_o,            // Operation altered.
  input wire logic        compat16_mode_o,          // Compat mode.
  input wire logic        loop_end_check_o,         // Loop end seen.
  input wire logic [24:0] loop_passes_o,            // Pass count.
  input wire logic [23:0] mv_result_o,              // Move result.
  input wire logic [23:0] agu_result_o              // Address result.
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  logic compat_q;
  // Compat is trusted only once it has held for two samples.
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      compat_q <= 1'b0;
    end else begin
      compat_q <= compat16_mode_o;
    end
  end
  wire cst = compat16_mode_o & compat_q;
  chk_reset_clear: assert property (disable iff (1'b0)
    !rst_b_i |-> rdata_o == 24'h000000 && !sixteen_bit_arith_mode_o && !double_prec_mult_mode_o && !compat16_mode_o)
    else $error("outputs not clear in reset");
  chk_alter_cause: assert property (
    dp_op_alter_o |-> $past(dp_op_i)) else $error("alter without operation");
  chk_check_gate: assert property (
    loop_end_check_o |-> $past(loop_end_hit_i)) else $error("loop end check without hit");
  chk_mode_write: assert property (
    $changed(sixteen_bit_arith_mode_o) |-> ($past(wr_i) && $past(addr_i) == 4'h0) ||
    ($past(wr_i, 2) && $past(addr_i, 2) == 4'h0)) else $error("arith mode changed without write");
  chk_compat_delay: assert property (
    wr_i && addr_i == 4'h0 && wdata_i[13] && !compat16_mode_o |=> !compat16_mode_o [*3])
    else $error("compat change too early");
  chk_move_mask: assert property (
    cst && $past(mv_ctrl_i) && !$past(mv_dst_stat_i) |-> mv_result_o == ($past(mv_data_i) & 24'h00ffff))
    else $error("move top byte kept");
  chk_agu_mask: assert property (
    cst && $past(agu_rd_i) |-> agu_result_o == ($past(agu_data_i) & 24'h00ffff)) else $error("address top byte kept");
  chk_count_wrap: assert property (
    cst && $past(loop_count_i) == 24'h000000 |-> loop_passes_o == 25'h0010000) else $error("zero count wrong");
endmodule // csm_checker
bind core_status_mode_bits csm_checker i_csm_checker (.clk_sys_i, .rst_b_i, .addr_i, .wdata_i, .wr_i,
  .loop_end_hit_i, .loop_count_i, .mv_ctrl_i, .mv_dst_stat_i, .mv_data_i, .agu_rd_i, .agu_data_i, .dp_op_i, .rdata_o,
  .sixteen_bit_arith_mode_o, .double_prec_mult_mode_o, .dp_op_alter_o, .compat16_mode_o, .loop_end_check_o,
  .loop_passes_o, .mv_result_o, .agu_result_o);
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench for the status and mode bank.
// ==========================================
module tb_top;
  logic        clk_sys_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [3:0]  addr_i = 4'h0, ev = 4'h0;
  logic [23:0] wdata_i = 24'h000000, loop_count_i = 24'h000000;
  logic        loop_end_hit_i = 1'b0, mv_ctrl_i = 1'b0, mv_dst_stat_i = 1'b0, agu_rd_i = 1'b0, dp_op_i = 1'b0;
  logic        mv_src_stat_i = 1'b0;
  logic [23:0] rdata_o, mv_result_o, agu_result_o, map_addr_o;
  logic [24:0] loop_passes_o;
  logic        sixteen_bit_arith_mode_o, double_prec_mult_mode_o, dp_op_alter_o, compat16_mode_o, loop_end_check_o;
  int          error_cnt = 0, comparisons = 0, cycles = 0;
  // The event vector carries loop start, endless start, exit and interrupt return.
  core_status_mode_bits i_core_status_mode_bits (.clk_sys_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .loop_start_i(ev[0]), .endless_start_i(ev[1]), .loop_exit_i(ev[2]), .rti_i(ev[3]), .loop_end_hit_i,
    .loop_count_i, .mv_ctrl_i, .mv_src_stat_i, .mv_dst_stat_i, .mv_data_i(24'hab1234),
    .mv_dst_old_i(24'hcd0000), .agu_rd_i, .agu_data_i(24'hef5678), .addr_in_i(24'h7f0100), .dp_op_i,
    .sixteen_bit_arith_mode_o, .double_prec_mult_mode_o, .dp_op_alter_o, .compat16_mode_o, .loop_end_check_o,
    .loop_passes_o, .mv_result_o, .agu_result_o, .map_addr_o);
  // Clock and hang guard.
  initial forever #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic check(input logic [24:0] got, input logic [24:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // Bus cycles and event pulses, each one clock long.
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [23:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    check({1'b0, rdata_o}, {1'b0, exp});
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge clk_sys_i);
    ev <= v;
    @(posedge clk_sys_i);
    ev <= 4'h0;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    cyc(1);
    check(sixteen_bit_arith_mode_o | double_prec_mult_mode_o | compat16_mode_o, 0);
    rd(4'h0, 24'h000000);
    wr(4'h0, 24'hffffff);
    #1;
    check(compat16_mode_o, 0);
    rd(4'h0, 24'h03e000);
    cyc(6);
    check({sixteen_bit_arith_mode_o, double_prec_mult_mode_o, compat16_mode_o}, 3'h7);
    wr(4'h3, 24'h000000);
    rd(4'h3, 24'h000001);
    rd(4'h9, 24'h000000);
    for (int c = 0; c < 2; c++) begin
      wr(4'h0, c ? 24'h002000 : 24'h000000);
      cyc(6);
      @(posedge clk_sys_i);
      loop_count_i <= 24'h000000;
      mv_ctrl_i <= 1'b1;
      mv_dst_stat_i <= 1'b0;
      agu_rd_i <= 1'b1;
      cyc(2);
      check(loop_passes_o, c ? 25'h0010000 : 25'h0000000);
      check(mv_result_o, c ? 24'h001234 : 24'hab1234);
      check(agu_result_o, c ? 24'h005678 : 24'hef5678);
      check(map_addr_o, c ? 24'h000100 : 24'h7f0100);
      @(posedge clk_sys_i);
      loop_count_i <= 24'hffffff;
      mv_ctrl_i <= 1'b0;
      mv_dst_stat_i <= 1'b1;
      cyc(2);
      check(loop_passes_o, c ? 25'h000ffff : 25'h0ffffff);
      check(mv_result_o, c ? 24'hcd1234 : 24'hab1234);
      rd(4'h2, c ? 24'h00ffff : 24'hffffff);
      @(posedge clk_sys_i);
      mv_dst_stat_i <= 1'b0;
      mv_src_stat_i <= 1'b1;
      cyc(2);
      check(mv_result_o, c ? 24'h001234 : 24'hab1234);
      @(posedge clk_sys_i);
      mv_src_stat_i <= 1'b0;
    end
    wr(4'h0, 24'h004000);
    @(posedge clk_sys_i);
    dp_op_i <= 1'b1;
    cyc(3);
    check(dp_op_alter_o, 1);
    @(posedge clk_sys_i);
    dp_op_i <= 1'b0;
    loop_end_hit_i <= 1'b1;
    cyc(2);
    check({dp_op_alter_o, loop_end_check_o}, 0);
    pulse(4'h1);
    rd(4'h0, 24'h00c000);
    check(loop_end_check_o, 1);
    rd(4'h1, 24'h000004);
    pulse(4'h2);
    rd(4'h0, 24'h01c000);
    rd(4'h1, 24'h000009);
    pulse(4'h4);
    rd(4'h0, 24'h00c000);
    pulse(4'h8);
    rd(4'h0, 24'h004000);
    rst_b_i <= 1'b0;
    cyc(2);
    rst_b_i <= 1'b1;
    rd(4'h0, 24'h000000);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
